// >>> verilog/sbx_pkg.sv
/*
  sbx_pkg: constants shared by the halt / subtract-with-borrow execute block.
  Assumes a 32-bit APB register port and an 8-bit data file with a 4-bit bank select.
*/
package sbx_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned FADDR_W = 12;
  // opcode encodings
  localparam logic [15:0] OPC_HALT = 16'h0003;
  localparam logic [5:0] OPC_SUBB_TOP = 6'h15;
  // operand fields of the byte-oriented word
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACC_BIT = 8;
  // access bank: low half maps to bank 0, high half to the top bank
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  // register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_PWR = 8'h10;
  // arithmetic status bit positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DIGIT = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OVF = 3;
  localparam int unsigned ST_N = 4;
  // power register bit positions
  localparam int unsigned PW_TIMEOUT = 0;
  localparam int unsigned PW_PWRDN = 1;
  localparam int unsigned PW_SLEEP = 2;
  localparam int unsigned PW_BUSY = 3;
  localparam int unsigned PW_ILL = 4;
  // reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_STAT = 5'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_PWRDN = 1'b1;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  typedef enum logic [2:0] {
    SBX_IDLE,
    SBX_DECODE,
    SBX_READ,
    SBX_PROC,
    SBX_WRITE
  } sbx_state_e;
endpackage

// >>> verilog/sbx_sub_borrow_alu.sv
/*
  sbx_sub_borrow_alu: combinational acc - file - !carry with all five status results.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
module sbx_sub_borrow_alu
  import sbx_pkg::*;
#(
  parameter int unsigned W = DATA_W
) (
  input wire logic [W-1:0] acc_i,
  input wire logic [W-1:0] file_i,
  input wire logic carry_i,
  output logic [W-1:0] res_o,
  output logic carry_o,
  output logic dcarry_o,
  output logic ovf_o,
  output logic neg_o,
  output logic zero_o
);
  // subtraction with borrow done as acc + ~file + carry
  wire logic [W:0] full_sum;
  wire logic [4:0] low_sum;
  assign full_sum = {1'b0, acc_i} + {1'b0, ~file_i} + {{W{1'b0}}, carry_i};
  assign low_sum = {1'b0, acc_i[3:0]} + {1'b0, ~file_i[3:0]} + {4'h0, carry_i};
  assign res_o = full_sum[W-1:0];
  assign carry_o = full_sum[W];
  assign dcarry_o = low_sum[4];
  assign ovf_o = (acc_i[W-1] != file_i[W-1]) && (res_o[W-1] != acc_i[W-1]);
  assign neg_o = res_o[W-1];
  assign zero_o = (res_o == '0);
endmodule // sbx_sub_borrow_alu

// >>> verilog/sbx_exec.sv
/*
  sbx_exec: executes the low-power halt and subtract-with-borrow instructions
  handed in over APB, on a four-phase instruction cycle, with a port to the data file.
  Assumes the data file answers a read combinationally in the cycle FILE_RE_O is high,
  and that wake-up sources and the watchdog itself live outside.
*/
`timescale 1ns/10ps
module sbx_exec
  import sbx_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [FADDR_W-1:0] FILE_ADDR_O,
  output logic FILE_RE_O,
  input wire logic [DATA_W-1:0] FILE_RDATA_I,
  output logic FILE_WE_O,
  output logic [DATA_W-1:0] FILE_WDATA_O,
  output logic OSC_STOP_O,
  output logic WATCHDOG_CLR_O,
  input wire logic WAKE_I,
  input wire logic WATCHDOG_WAKE_I
);
  function automatic logic [BANK_W-1:0] pick_bank(input logic acc_sel, input logic f_top,
                                                  input logic [BANK_W-1:0] bank_sel);
    if (!acc_sel) begin
      pick_bank = f_top ? ACC_HIGH_BANK : ACC_LOW_BANK;
    end else begin
      pick_bank = bank_sel;
    end
  endfunction

  sbx_state_e state;
  logic [1:0] phase;
  logic [15:0] instr;
  logic pend;
  logic [DATA_W-1:0] acc;
  logic [4:0] stat;
  logic [BANK_W-1:0] bank_select_reg;
  logic timeout_flag;
  logic powerdown_flag;
  logic sleeping;
  logic illegal;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;

  // free-running phase divider; cycle_start marks the next Q1
  wire logic cycle_start;
  assign cycle_start = (phase == PHASE_LAST);

  // apb decode
  wire logic acc_phase;
  wire logic wr_en;
  wire logic hit_instr;
  wire logic hit_acc;
  wire logic hit_stat;
  wire logic hit_bank;
  wire logic hit_pwr;
  wire logic mapped;
  assign acc_phase = PSEL_I && PENABLE_I;
  assign wr_en = acc_phase && PWRITE_I;
  assign hit_instr = (PADDR_I == OFS_INSTR);
  assign hit_acc = (PADDR_I == OFS_ACC);
  assign hit_stat = (PADDR_I == OFS_STAT);
  assign hit_bank = (PADDR_I == OFS_BANK);
  assign hit_pwr = (PADDR_I == OFS_PWR);
  assign mapped = hit_instr || hit_acc || hit_stat || hit_bank || hit_pwr;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc_phase && !mapped;

  wire logic [31:0] pwr_word;
  assign pwr_word = {27'h0, illegal, pend, sleeping, powerdown_flag, timeout_flag};
  wire logic [31:0] next_prdata;
  assign next_prdata = hit_instr ? {16'h0, instr} :
                       hit_acc ? {24'h0, acc} :
                       hit_stat ? {27'h0, stat} :
                       hit_bank ? {28'h0, bank_select_reg} :
                       hit_pwr ? pwr_word : 32'h0;

  // instruction decode
  wire logic is_halt;
  wire logic is_subb;
  wire logic dest_file;
  wire logic [BANK_W-1:0] bank;
  assign is_halt = (instr == OPC_HALT);
  assign is_subb = (instr[15:10] == OPC_SUBB_TOP);
  assign dest_file = instr[DEST_BIT];
  assign bank = pick_bank(instr[ACC_BIT], instr[7], bank_select_reg);

  wire logic [DATA_W-1:0] alu_res;
  wire logic alu_c;
  wire logic alu_dc;
  wire logic alu_ov;
  wire logic alu_n;
  wire logic alu_z;
  sbx_sub_borrow_alu #(
    .W(DATA_W)
  ) u_alu (
    .acc_i(acc),
    .file_i(operand),
    .carry_i(stat[ST_C]),
    .res_o(alu_res),
    .carry_o(alu_c),
    .dcarry_o(alu_dc),
    .ovf_o(alu_ov),
    .neg_o(alu_n),
    .zero_o(alu_z)
  );

  // a new word is refused while one is still pending or running
  wire logic take_instr;
  wire logic halt_exec;
  wire logic wake;
  assign take_instr = wr_en && hit_instr && !pend;
  assign halt_exec = (state == SBX_DECODE) && is_halt;
  assign wake = sleeping && (WAKE_I || WATCHDOG_WAKE_I);
  wire logic ill_set;
  wire logic ill_clr;
  assign ill_set = (state == SBX_DECODE) && !is_subb && !is_halt;
  assign ill_clr = wr_en && hit_pwr && PWDATA_I[PW_ILL];

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= next_prdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state <= SBX_IDLE;
      pend <= 1'b0;
      instr <= 16'h0;
      illegal <= 1'b0;
    end else begin
      if (take_instr) begin
        instr <= PWDATA_I[15:0];
        pend <= 1'b1;
      end
      // execution waits for the cycle boundary and is frozen while halted
      unique case (state)
        SBX_IDLE: begin
          if (pend && cycle_start && !sleeping) begin
            state <= SBX_DECODE;
          end
        end
        SBX_DECODE: begin
          if (is_subb) begin
            state <= SBX_READ;
          end else begin
            state <= SBX_IDLE;
            pend <= 1'b0;
            illegal <= illegal || !is_halt;
          end
        end
        SBX_READ: state <= SBX_PROC;
        SBX_PROC: state <= SBX_WRITE;
        SBX_WRITE: begin
          state <= SBX_IDLE;
          pend <= 1'b0;
        end
        default: state <= SBX_IDLE;
      endcase
      // sticky: a new illegal word in the same cycle wins over the clear
      if (ill_clr && !ill_set) begin
        illegal <= 1'b0;
      end
    end
  end

  // data file port and operand capture
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      FILE_ADDR_O <= '0;
      FILE_RE_O <= 1'b0;
      FILE_WE_O <= 1'b0;
      FILE_WDATA_O <= '0;
      operand <= '0;
      result <= '0;
    end else begin
      FILE_RE_O <= (state == SBX_DECODE) && is_subb;
      FILE_WE_O <= (state == SBX_PROC) && dest_file;
      if (state == SBX_DECODE) begin
        FILE_ADDR_O <= {bank, instr[7:0]};
      end
      if (state == SBX_READ) begin
        operand <= FILE_RDATA_I;
      end
      if (state == SBX_PROC) begin
        result <= alu_res;
        FILE_WDATA_O <= alu_res;
      end
    end
  end

  // hardware updates take priority over a software write in the same cycle
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      acc <= RST_ACC;
      stat <= RST_STAT;
      bank_select_reg <= RST_BANK;
    end else begin
      if (wr_en && hit_acc) begin
        acc <= PWDATA_I[7:0];
      end
      if (wr_en && hit_stat) begin
        stat <= PWDATA_I[4:0];
      end
      if (wr_en && hit_bank) begin
        bank_select_reg <= PWDATA_I[3:0];
      end
      if (state == SBX_PROC) begin
        stat[ST_C] <= alu_c;
        stat[ST_DIGIT] <= alu_dc;
        stat[ST_Z] <= alu_z;
        stat[ST_OVF] <= alu_ov;
        stat[ST_N] <= alu_n;
      end
      if (state == SBX_WRITE && !dest_file) begin
        acc <= result;
      end
    end
  end

  // halt and wake
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      timeout_flag <= RST_TIMEOUT;
      powerdown_flag <= RST_PWRDN;
      sleeping <= 1'b0;
      WATCHDOG_CLR_O <= 1'b0;
    end else begin
      WATCHDOG_CLR_O <= halt_exec;
      if (halt_exec) begin
        sleeping <= 1'b1;
        powerdown_flag <= 1'b0;
        timeout_flag <= 1'b1;
      end else if (wake) begin
        sleeping <= 1'b0;
        if (WATCHDOG_WAKE_I) begin
          timeout_flag <= 1'b0;
        end
      end
    end
  end

  assign OSC_STOP_O = sleeping;
endmodule // sbx_exec

// >>> testbench/sbx_exec_monitor.sv
/*
  sbx_exec_monitor: port-level assertions for sbx_exec.
  Assumes the bind below attaches it to every sbx_exec instance.
*/
`timescale 1ns/10ps
module sbx_exec_monitor
  import sbx_pkg::*;
(
  input logic CLK_I,
  input logic RSTN_I,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic [7:0] PADDR_I,
  input logic PREADY_O,
  input logic PSLVERR_O,
  input logic [FADDR_W-1:0] FILE_ADDR_O,
  input logic FILE_RE_O,
  input logic FILE_WE_O,
  input logic OSC_STOP_O,
  input logic WATCHDOG_CLR_O,
  input logic WAKE_I,
  input logic WATCHDOG_WAKE_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  ready_always_a: assert property (PREADY_O) else $error("pready low");
  unmapped_err_a: assert property (PSEL_I && PENABLE_I && PADDR_I > OFS_PWR |-> PSLVERR_O)
    else $error("no slave error");
  write_after_read_a: assert property (FILE_WE_O |-> $past(FILE_RE_O, 2))
    else $error("file write not two cycles after read");
  write_same_addr_a: assert property (
    FILE_WE_O |-> FILE_ADDR_O == $past(FILE_ADDR_O, 2)) else $error("write address moved");
  read_one_cycle_a: assert property (FILE_RE_O |=> !FILE_RE_O) else $error("long read");
  halt_clears_watchdog_a: assert property ($rose(OSC_STOP_O) |-> WATCHDOG_CLR_O)
    else $error("no watchdog clear");
  watchdog_pulse_a: assert property (WATCHDOG_CLR_O |=> !WATCHDOG_CLR_O)
    else $error("long clear");
  halt_holds_a: assert property (OSC_STOP_O && !WAKE_I && !WATCHDOG_WAKE_I |=> OSC_STOP_O)
    else $error("left halt unwoken");
  wake_runs_a: assert property (OSC_STOP_O && (WAKE_I || WATCHDOG_WAKE_I) |=> !OSC_STOP_O)
    else $error("wake ignored");
  halt_no_file_a: assert property (OSC_STOP_O |-> !FILE_RE_O && !FILE_WE_O)
    else $error("file access while halted");
  cover property (FILE_WE_O);
  cover property ($rose(OSC_STOP_O));
  cover property (OSC_STOP_O && WATCHDOG_WAKE_I);
endmodule // sbx_exec_monitor

bind sbx_exec sbx_exec_monitor u_mon (.CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PADDR_I,
  .PREADY_O, .PSLVERR_O, .FILE_ADDR_O, .FILE_RE_O, .FILE_WE_O, .OSC_STOP_O, .WATCHDOG_CLR_O,
  .WAKE_I, .WATCHDOG_WAKE_I);

// >>> testbench/tb_top.sv
/*
  tb_top: self-checking bench for sbx_exec over APB.
  Assumes the bench itself answers file reads in the cycle the read strobe is high.
*/
`timescale 1ns/10ps
module tb_top
  import sbx_pkg::*;
;
  logic CLK_I = 0, RSTN_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic WAKE_I = 0, WATCHDOG_WAKE_I = 0;
  logic [7:0] PADDR_I = 0;
  logic [31:0] PWDATA_I = 0, PRDATA_O, rd;
  logic PREADY_O, PSLVERR_O, FILE_RE_O, FILE_WE_O, OSC_STOP_O, WATCHDOG_CLR_O, slv;
  logic [11:0] FILE_ADDR_O, we_adr;
  logic [7:0] FILE_WDATA_O, we_dat, fdat = 0, w, f;
  logic [3:0] b;
  logic [12:0] x;
  logic c, d, a;
  wire [7:0] FILE_RDATA_I = FILE_RE_O ? fdat : ~fdat; // junk outside the read cycle
  // pulse counters live in one process; scenarios take a snapshot and compare the difference
  int err_total = 0, compares = 0, clr_n = 0, we_n = 0, n0 = 0;
  sbx_exec DUT (.CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .FILE_ADDR_O, .FILE_RE_O, .FILE_RDATA_I,
    .FILE_WE_O, .FILE_WDATA_O, .OSC_STOP_O, .WATCHDOG_CLR_O, .WAKE_I, .WATCHDOG_WAKE_I);
  initial forever #4 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    if (FILE_WE_O === 1'b1) begin
      we_n <= we_n + 1;
      we_adr <= FILE_ADDR_O;
      we_dat <= FILE_WDATA_O;
    end
    if (WATCHDOG_CLR_O === 1'b1) begin
      clr_n <= clr_n + 1;
    end
  end
  task close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    @(posedge CLK_I);
    PSEL_I <= 1;
    PENABLE_I <= 0;
    PWRITE_I <= wr;
    PADDR_I <= ad;
    PWDATA_I <= dt;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    n = 0;
    do begin @(posedge CLK_I); n++; end while (PREADY_O !== 1'b1 && n < 50);
    if (PREADY_O !== 1'b1) begin err_total++; close_out(); end
    rd = PRDATA_O;
    slv = PSLVERR_O;
    PSEL_I <= 0;
    PENABLE_I <= 0;
  endtask
  // polls busy; execution waits for the phase counter, so no fixed delay is assumed
  task idle;
    int n;
    n = 0;
    do begin apb(0, OFS_PWR, 0); n++; end while (rd[PW_BUSY] !== 1'b0 && n < 40);
    if (rd[PW_BUSY] !== 1'b0) begin err_total++; close_out(); end
  endtask
  function automatic logic [12:0] subx(input logic [7:0] wv, fv, input logic cv);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, wv} + {1'b0, ~fv} + 9'(cv);
    l = {1'b0, wv[3:0]} + {1'b0, ~fv[3:0]} + 5'(cv);
    return {s[7], wv[7] != fv[7] && s[7] != wv[7], s[7:0] == 0, l[4], s[8], s[7:0]};
  endfunction
  // expected file address: access bank split at 80h unless the access bit picks the bank select
  function automatic logic [11:0] exp_adr(input logic [3:0] bv, input logic [7:0] fv,
                                          input logic av);
    return {av ? bv : (fv[7] ? ACC_HIGH_BANK : ACC_LOW_BANK), fv};
  endfunction
  initial begin
    void'($urandom(32'h4968));
    repeat (16) @(posedge CLK_I);
    RSTN_I <= 1;
    apb(0, OFS_PWR, 0);
    chk("pwr", 32'h3, rd);
    apb(0, 8'h20, 0);
    chk("err", 1, slv);
    for (int i = 0; i < 14; i++) begin
      {w, f, b, c, d, a} = 23'($urandom);
      fdat = 8'($urandom);
      if (i < 2) begin // zero, then overflow
        w = i ? 8'h80 : 8'h00;
        fdat = 8'(i);
        c = 1;
      end
      apb(1, OFS_ACC, {24'h0, w});
      apb(1, OFS_STAT, {31'h0, c});
      apb(1, OFS_BANK, {28'h0, b});
      n0 = we_n;
      apb(1, OFS_INSTR, {16'h0, OPC_SUBB_TOP, d, a, f});
      idle;
      x = subx(w, fdat, c);
      apb(0, OFS_STAT, 0);
      chk("stat", {27'h0, x[12:8]}, rd);
      apb(0, OFS_ACC, 0);
      chk("acc", {24'h0, d ? w : x[7:0]}, rd);
      chk("we", {31'h0, d}, we_n - n0);
      chk("fadr", exp_adr(b, f, a), FILE_ADDR_O);
      if (d) chk("wadr", exp_adr(b, f, a), we_adr);
      if (d) chk("wdat", x[7:0], we_dat);
    end
    apb(1, OFS_INSTR, 32'h4);
    idle;
    chk("ill", 1, rd[PW_ILL]);
    chk("osc", 0, OSC_STOP_O);
    apb(1, OFS_PWR, 32'h10);
    apb(0, OFS_PWR, 0);
    chk("ill", 0, rd[PW_ILL]);
    // a second word written while the first still runs must be dropped
    apb(1, OFS_INSTR, {16'h0, OPC_SUBB_TOP, 10'h0});
    apb(1, OFS_INSTR, {16'h0, OPC_HALT});
    idle;
    chk("osc", 0, OSC_STOP_O);
    // the middle pass wakes on the watchdog, so the last halt must raise the time-out flag again
    for (int k = 0; k < 3; k++) begin
      n0 = clr_n;
      apb(1, OFS_INSTR, {16'h0, OPC_HALT});
      idle;
      chk("pdn", 0, rd[PW_PWRDN]);
      chk("tmo", 1, rd[PW_TIMEOUT]);
      chk("slp", 1, rd[PW_SLEEP]);
      chk("osc", 1, OSC_STOP_O);
      chk("clr", 1, clr_n - n0);
      @(posedge CLK_I);
      {WATCHDOG_WAKE_I, WAKE_I} <= (k == 1) ? 2'b10 : 2'b01;
      @(posedge CLK_I);
      {WATCHDOG_WAKE_I, WAKE_I} <= 2'b00;
      apb(0, OFS_PWR, 0);
      chk("wake", (k == 1) ? 0 : 1, rd & 32'hf);
      chk("osc", 0, OSC_STOP_O);
    end
    close_out();
  end
endmodule // tb_top
